// ==== hdl/mss_startup_cfg.sv ====
`timescale 1ns/1ns
module mss_startup_cfg
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic motor_start,
    input wire logic motor_stop,
    output logic motor_running,
    output mss_pkg::mss_method_t startup_method_sel,
    output logic [3:0] align_ramp_code,
    output logic [13:0] align_ramp_rate_dv,
    output logic [3:0] align_time_code,
    output logic [13:0] align_time_ms,
    output logic [3:0] align_current_limit,
    output logic align_current_limit_valid,
    output logic [2:0] position_probe_clock_rate,
    output logic [13:0] position_probe_clock_hz,
    output logic [13:0] startup_tail
);
    // ==========================================================
    // Decode tables
    // Ramp rate in tenths of a volt per second
    function automatic logic [13:0] ramp_dv(input logic [3:0] code);
        logic [13:0] tbl [16];
        tbl = '{14'h0001, 14'h0002, 14'h0005, 14'h000A, 14'h0019, 14'h0032, 14'h004B, 14'h0064,
                14'h00FA, 14'h01F4, 14'h02EE, 14'h03E8, 14'h09C4, 14'h1388, 14'h1D4C, 14'h2710};
        return tbl[code];
    endfunction

    function automatic logic [13:0] time_ms(input logic [3:0] code);
        logic [13:0] tbl [16];
        tbl = '{14'h0005, 14'h000A, 14'h0019, 14'h0032, 14'h004B, 14'h0064, 14'h00C8, 14'h0190,
                14'h0258, 14'h0320, 14'h03E8, 14'h07D0, 14'h0FA0, 14'h1770, 14'h1F40, 14'h2710};
        return tbl[code];
    endfunction

    function automatic logic [13:0] probe_hz(input logic [2:0] code);
        logic [13:0] tbl [8];
        tbl = '{14'h0032, 14'h0064, 14'h00FA, 14'h01F4, 14'h03E8, 14'h07D0, 14'h1388, 14'h2710};
        return tbl[code];
    endfunction

    // ==========================================================
    // Register port
    logic [31:0] startup_one;
    logic hit_wr;
    logic hit_rd;
    assign hit_wr = reg_wr && (reg_addr == mss_pkg::STARTUP_ONE_OFFSET);
    assign hit_rd = reg_rd && (reg_addr == mss_pkg::STARTUP_ONE_OFFSET);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            startup_one <= mss_pkg::STARTUP_ONE_RESET;
        else if (hit_wr)
            startup_one <= reg_wdata;
    end

    // Unmapped reads answer zero; answer follows one edge later
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            reg_rdata <= hit_rd ? startup_one : 32'h00000000;
        end
    end

    // ==========================================================
    // Run state
    mss_pkg::mss_state_t state;
    mss_pkg::mss_state_t next_state;
    logic take_start;
    assign take_start = (state == mss_pkg::MSS_IDLE) && motor_start;

    always_comb
    begin
        next_state = state;
        unique case (state)
            mss_pkg::MSS_IDLE:
            begin
                if (motor_start)
                    next_state = mss_pkg::MSS_RUN;
            end
            mss_pkg::MSS_RUN:
            begin
                if (motor_stop)
                    next_state = mss_pkg::MSS_IDLE;
            end
            default:
                next_state = mss_pkg::MSS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            state <= mss_pkg::MSS_IDLE;
        else
            state <= next_state;
    end

    assign motor_running = (state == mss_pkg::MSS_RUN);

    // ==========================================================
    // Start snapshot
    // Sampling only at start keeps a running motor from jumping between methods
    logic [31:0] snap;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            snap <= mss_pkg::STARTUP_ONE_RESET;
        else if (take_start)
            snap <= startup_one;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            startup_method_sel <= mss_pkg::MSS_SINGLE_ALIGN;
            align_ramp_code <= 4'h0;
            align_ramp_rate_dv <= 14'h0000;
            align_time_code <= 4'h0;
            align_time_ms <= 14'h0000;
            align_current_limit <= 4'h0;
            align_current_limit_valid <= 1'b0;
            position_probe_clock_rate <= 3'h0;
            position_probe_clock_hz <= 14'h0000;
            startup_tail <= 14'h0000;
        end
        else
        begin
            startup_method_sel <= mss_pkg::mss_method_t'(snap[mss_pkg::METHOD_LSB +: mss_pkg::METHOD_W]);
            align_ramp_code <= snap[mss_pkg::RAMP_LSB +: mss_pkg::RAMP_W];
            align_ramp_rate_dv <= ramp_dv(snap[mss_pkg::RAMP_LSB +: mss_pkg::RAMP_W]);
            align_time_code <= snap[mss_pkg::ALIGN_TIME_LSB +: mss_pkg::ALIGN_TIME_W];
            align_time_ms <= time_ms(snap[mss_pkg::ALIGN_TIME_LSB +: mss_pkg::ALIGN_TIME_W]);
            align_current_limit <= snap[mss_pkg::CURR_LSB +: mss_pkg::CURR_W];
            align_current_limit_valid <=
                snap[mss_pkg::CURR_LSB +: mss_pkg::CURR_W] != mss_pkg::CURR_NOT_APPLICABLE;
            position_probe_clock_rate <= snap[mss_pkg::PROBE_CLK_LSB +: mss_pkg::PROBE_CLK_W];
            position_probe_clock_hz <= probe_hz(snap[mss_pkg::PROBE_CLK_LSB +: mss_pkg::PROBE_CLK_W]);
            startup_tail <= snap[mss_pkg::TAIL_W-1:0];
        end
    end

    // ==========================================================
    // Checks
    AST_WRITE_READBACK: assert property (@(posedge mclk) disable iff (!arst_n)
        hit_wr ##1 (reg_rd && reg_addr == mss_pkg::STARTUP_ONE_OFFSET && !reg_wr)
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
        else $error("Readback differs from written word");

    AST_UNMAPPED_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
        (reg_rd && reg_addr != mss_pkg::STARTUP_ONE_OFFSET) |=> reg_rvalid && reg_rdata == 32'h00000000)
        else $error("Unmapped read not zero");

    AST_READ_ANSWER: assert property (@(posedge mclk) disable iff (!arst_n)
        reg_rd |=> reg_rvalid)
        else $error("Read not answered one edge later");

    AST_NO_STRAY_ANSWER: assert property (@(posedge mclk) disable iff (!arst_n)
        !reg_rd |=> !reg_rvalid)
        else $error("Read answer without a read");

    AST_METHOD_FROM_START: assert property (@(posedge mclk) disable iff (!arst_n)
        take_start |-> ##2
            startup_method_sel == $past(startup_one[mss_pkg::METHOD_LSB +: mss_pkg::METHOD_W], 2))
        else $error("Method not taken from register at start");

    AST_TIME_DECODE: assert property (@(posedge mclk) disable iff (!arst_n)
        (take_start
            && startup_one[mss_pkg::ALIGN_TIME_LSB +: mss_pkg::ALIGN_TIME_W] == mss_pkg::ALIGN_TIME_LONGEST_CODE)
        |-> ##2 align_time_ms == mss_pkg::ALIGN_TIME_LONGEST_MS)
        else $error("Align time decode wrong");

    AST_RAMP_DECODE: assert property (@(posedge mclk) disable iff (!arst_n)
        (take_start
            && startup_one[mss_pkg::RAMP_LSB +: mss_pkg::RAMP_W] == mss_pkg::RAMP_SLOWEST_CODE)
        |-> ##2 align_ramp_rate_dv == mss_pkg::RAMP_SLOWEST_DV)
        else $error("Ramp rate decode wrong");

    AST_CURR_NA: assert property (@(posedge mclk) disable iff (!arst_n)
        take_start |-> ##2
            align_current_limit_valid
                == ($past(startup_one[mss_pkg::CURR_LSB +: mss_pkg::CURR_W], 2) != mss_pkg::CURR_NOT_APPLICABLE))
        else $error("Current limit validity wrong");

    AST_CURR_CODE: assert property (@(posedge mclk) disable iff (!arst_n)
        take_start |-> ##2
            align_current_limit == $past(startup_one[mss_pkg::CURR_LSB +: mss_pkg::CURR_W], 2))
        else $error("Current limit code not taken at start");

    AST_HOLD_WHILE_RUN: assert property (@(posedge mclk) disable iff (!arst_n)
        (motor_running && !motor_stop) |=> $stable(snap))
        else $error("Snapshot changed while running");

    AST_START_TAKEN: assert property (@(posedge mclk) disable iff (!arst_n)
        (!motor_running && motor_start) |=> motor_running)
        else $error("Start while idle not taken");

    AST_STOP_TAKEN: assert property (@(posedge mclk) disable iff (!arst_n)
        (motor_running && motor_stop) |=> !motor_running)
        else $error("Stop while running not taken");

    // Outputs settle one edge after the snapshot, so hold counts from the second running edge
    AST_OUTPUTS_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
        (motor_running ##1 motor_running)
        |=> $stable(startup_method_sel) && $stable(align_ramp_rate_dv) && $stable(align_time_ms)
            && $stable(align_current_limit) && $stable(position_probe_clock_hz) && $stable(startup_tail))
        else $error("Start-up outputs moved while running");
endmodule

// ==== hdl/mss_pkg.sv ====
package mss_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] STARTUP_ONE_OFFSET = 8'h82;
    localparam logic [31:0] STARTUP_ONE_RESET = 32'h00000000;

    // ==========================================================
    // Field layout
    localparam int PARITY_BIT = 31;
    localparam int METHOD_LSB = 29;
    localparam int METHOD_W = 2;
    localparam int RAMP_LSB = 25;
    localparam int RAMP_W = 4;
    localparam int ALIGN_TIME_LSB = 21;
    localparam int ALIGN_TIME_W = 4;
    localparam int CURR_LSB = 17;
    localparam int CURR_W = 4;
    localparam int PROBE_CLK_LSB = 14;
    localparam int PROBE_CLK_W = 3;
    localparam int TAIL_W = 14;
    localparam logic [3:0] CURR_NOT_APPLICABLE = 4'h0;
    localparam logic [3:0] ALIGN_TIME_LONGEST_CODE = 4'hF;
    localparam logic [13:0] ALIGN_TIME_LONGEST_MS = 14'h2710;
    localparam logic [3:0] RAMP_SLOWEST_CODE = 4'h0;
    localparam logic [13:0] RAMP_SLOWEST_DV = 14'h0001;

    // ==========================================================
    // Start-up methods
    typedef enum logic [1:0]
    {
        MSS_SINGLE_ALIGN = 2'h0,
        MSS_DOUBLE_ALIGN = 2'h1,
        MSS_POSITION_PROBE = 2'h2,
        MSS_SLOW_FIRST_CYCLE = 2'h3
    } mss_method_t;

    // Motor run states
    typedef enum logic [1:0]
    {
        MSS_IDLE = 2'b01,
        MSS_RUN = 2'b10
    } mss_state_t;
endpackage

// ==== sim/mss_startup_cfg_tb.sv ====
`timescale 1ns/1ns
module mss_startup_cfg_tb;
    // ==========================================================
    // Signals and expectation tables
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic motor_start = 1'b0;
    logic motor_stop = 1'b0;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic motor_running;
    mss_pkg::mss_method_t startup_method_sel;
    logic [3:0] align_ramp_code;
    logic [13:0] align_ramp_rate_dv;
    logic [3:0] align_time_code;
    logic [13:0] align_time_ms;
    logic [3:0] align_current_limit;
    logic align_current_limit_valid;
    logic [2:0] position_probe_clock_rate;
    logic [13:0] position_probe_clock_hz;
    logic [13:0] startup_tail;
    int n_errors = 0;
    int check_count = 0;
    int ramp_tab[16] = '{1, 2, 5, 10, 25, 50, 75, 100, 250, 500, 750, 1000, 2500, 5000, 7500, 10000};
    int time_tab[16] = '{5, 10, 25, 50, 75, 100, 200, 400, 600, 800, 1000, 2000, 4000, 6000, 8000, 10000};
    int hz_tab[8] = '{50, 100, 250, 500, 1000, 2000, 5000, 10000};

    always #20 mclk = ~mclk;

    mss_startup_cfg dut_u
    (
        .mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .motor_start(motor_start), .motor_stop(motor_stop), .motor_running(motor_running),
        .startup_method_sel(startup_method_sel), .align_ramp_code(align_ramp_code),
        .align_ramp_rate_dv(align_ramp_rate_dv), .align_time_code(align_time_code),
        .align_time_ms(align_time_ms), .align_current_limit(align_current_limit),
        .align_current_limit_valid(align_current_limit_valid),
        .position_probe_clock_rate(position_probe_clock_rate),
        .position_probe_clock_hz(position_probe_clock_hz), .startup_tail(startup_tail)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rvalid, 1'b1);
        chk(reg_rdata, exp);
    endtask

    // Decoded outputs expected from a snapshot of word w
    task automatic outs(input logic [31:0] w);
        chk(startup_method_sel, w[30:29]);
        chk(align_ramp_code, w[28:25]);
        chk(align_ramp_rate_dv, 32'(ramp_tab[w[28:25]]));
        chk(align_time_code, w[24:21]);
        chk(align_time_ms, 32'(time_tab[w[24:21]]));
        chk(align_current_limit, w[20:17]);
        chk(align_current_limit_valid, w[20:17] != 4'h0);
        chk(position_probe_clock_rate, w[16:14]);
        chk(position_probe_clock_hz, 32'(hz_tab[w[16:14]]));
        chk(startup_tail, w[13:0]);
    endtask

    task automatic run(input logic go, input logic [31:0] w);
        @(posedge mclk);
        motor_start <= go;
        motor_stop <= ~go;
        @(posedge mclk);
        motor_start <= 1'b0;
        motor_stop <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk(motor_running, go);
        outs(w);
    endtask

    task automatic close_out;
        $display("comparisons=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // Reset values while held, decoded zero word one edge after release
    task automatic t_reset(input logic mid);
        if (mid)
        begin
            @(posedge mclk);
            arst_n <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        #1;
        chk(motor_running, 1'b0);
        chk(reg_rvalid, 1'b0);
        chk(reg_rdata, 32'h00000000);
        chk(startup_method_sel, 2'h0);
        chk(align_ramp_rate_dv, 14'h0000);
        chk(align_time_ms, 14'h0000);
        chk(position_probe_clock_hz, 14'h0000);
        @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk(motor_running, 1'b0);
        outs(32'h00000000);
        rd(8'h82, 32'h00000000);
    endtask

    task automatic t_bus;
        rd(8'h82, 32'h00000000);
        wr(8'h82, 32'hFFFFFFFF);
        rd(8'h82, 32'hFFFFFFFF);
        wr(8'h84, 32'h00000000);
        rd(8'h84, 32'h00000000);
        rd(8'h82, 32'hFFFFFFFF);
    endtask

    // Read on the edge right after a write, then the answer must drop
    task automatic t_b2b(input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h82;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rvalid, 1'b1);
        chk(reg_rdata, d);
        @(posedge mclk);
        #1;
        chk(reg_rvalid, 1'b0);
        chk(reg_rdata, 32'h00000000);
    endtask

    task automatic t_codes;
        logic [3:0] c;
        logic [31:0] w;
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            w = {c[0], c[1:0], c, ~c, c, c[2:0], 14'h1555 ^ {10'h000, c}};
            wr(8'h82, w);
            run(1'b1, w);
            run(1'b0, w);
        end
    endtask

    // Writes and a second start while running must not move the outputs
    task automatic t_hold;
        wr(8'h82, 32'h2A5E3C91);
        run(1'b1, 32'h2A5E3C91);
        wr(8'h82, 32'h55A1C36E);
        rd(8'h82, 32'h55A1C36E);
        run(1'b1, 32'h2A5E3C91);
        run(1'b0, 32'h2A5E3C91);
        run(1'b1, 32'h55A1C36E);
    endtask

    initial
    begin
        repeat (9) @(posedge mclk);
        t_reset(1'b0);
        t_bus();
        t_b2b(32'h1E2D3C4B);
        t_codes();
        t_hold();
        t_reset(1'b1);
        close_out();
    end

    // Hang guard, over twenty times the expected run
    initial
    begin
        #200000;
        n_errors++;
        close_out();
    end
endmodule
